// File: drive_model.sv
`timescale 1ns/100ps

module drive_model (
  input  logic clk,                 // System clock
  output logic drive_ready_in,      // Ready level
  output logic write_protect_in,    // Low when protected
  output logic head_load_timing_in, // Head settled
  output logic track_zero_in,       // Low at track zero
  output logic index_pulse_in,      // Low at index hole
  output logic separated_data_in,   // Data pulse
  output logic separated_clock_in   // Clock pulse
);
  initial begin
    {drive_ready_in, write_protect_in, head_load_timing_in} = 3'h7;
    {track_zero_in, index_pulse_in, separated_data_in, separated_clock_in} = 4'hC;
  end
  task automatic index_mark();
    @(posedge clk) index_pulse_in <= 1'b0;
    repeat (4) @(posedge clk);
    index_pulse_in <= 1'b1;
  endtask : index_mark
  // Data pulse first, then the clock pulse that shifts it in
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) separated_data_in <= b[i];
      @(posedge clk) separated_data_in <= 1'b0;
      separated_clock_in <= 1'b1;
      @(posedge clk) separated_clock_in <= 1'b0;
    end
  endtask : send_byte
endmodule : drive_model

// File: floppy_status_and_track_format.sv
`timescale 1ns/100ps

package floppy_pkg;
  localparam int        CLK_NS        = 4;
  localparam int        HALF_CELL_NS  = 2000;
  localparam int        HALF_CELL_CYC = HALF_CELL_NS / CLK_NS;
  localparam int        BUF_DEPTH     = 2;
  localparam int        ST_NRDY       = 7;
  localparam int        ST_B6         = 6;
  localparam int        ST_B5         = 5;
  localparam int        ST_B4         = 4;
  localparam int        ST_B3         = 3;
  localparam int        ST_B2         = 2;
  localparam int        ST_B1         = 1;
  localparam int        ST_BUSY       = 0;
  localparam logic [7:0]  STATUS_RST  = 8'h80;
  localparam logic [7:0]  CRC_CMD     = 8'hF7;
  localparam logic [7:0]  MARK_LO     = 8'hF8;
  localparam logic [7:0]  MARK_DATA_HI = 8'hFB;
  localparam logic [7:0]  MARK_IDX    = 8'hFC;
  localparam logic [7:0]  MARK_ID     = 8'hFE;
  localparam logic [7:0]  FILL        = 8'h00;
  localparam logic [7:0]  CLK_NORMAL  = 8'hFF;
  localparam logic [7:0]  CLK_MARK    = 8'hC7;
  localparam logic [7:0]  CLK_IDX     = 8'hD7;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h1021;

  typedef enum logic [5:0] {
    K_TYPE1 = 6'h01, K_RADDR = 6'h02, K_RREC = 6'h04,
    K_RTRK  = 6'h08, K_WREC  = 6'h10, K_WTRK = 6'h20
  } cmd_kind_e;

  typedef enum logic [3:0] {
    F_IDLE = 4'h1, F_WAIT = 4'h2, F_WRITE = 4'h4, F_CRC_LO = 4'h8
  } fmt_state_e;

  // CRC advanced in the same bit order as the bytes go out
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : crc_byte

  // Spare mark keeps a full clock pattern
  function automatic logic [7:0] clock_of(input logic [7:0] b);
    if (b == MARK_IDX) return CLK_IDX;
    if (b == MARK_ID || (b >= MARK_LO && b <= MARK_DATA_HI)) return CLK_MARK;
    return CLK_NORMAL;
  endfunction : clock_of
endpackage : floppy_pkg

module floppy_status_and_track_format (
  input  logic                  clk,                 // 250 MHz clock
  input  logic                  rst_n,               // Master reset, active low
  input  logic                  cmd_load,            // New command pulse
  input  floppy_pkg::cmd_kind_e cmd_kind,            // Command type
  input  logic                  cmd_force_int,       // Command is force interrupt
  input  logic [3:0]            force_cond,          // Force interrupt conditions
  input  logic                  cmd_done,            // Sequencer ends command
  input  logic                  seek_err_evt,        // Track verify failed
  input  logic                  crc_err_evt,         // CRC error seen
  input  logic                  rnf_evt,             // Record not found
  input  logic                  rec_type_evt,        // Record type valid
  input  logic [1:0]            rec_type,            // Record type bits
  input  logic                  drive_ready_in,      // Drive ready
  input  logic                  write_protect_in,    // Low when protected
  input  logic                  head_load_timing_in, // Head settled
  input  logic                  track_zero_in,       // Low at track zero
  input  logic                  index_pulse_in,      // Low at index hole
  input  logic                  status_rd,           // Status read strobe
  output logic [7:0]            status_data,         // Status snapshot
  input  logic                  data_wr,             // Data register write
  input  logic [7:0]            data_wr_byte,        // Written byte
  input  logic                  data_rd,             // Data register read
  output logic [7:0]            read_byte,           // Assembled byte
  input  logic                  separated_data_in,   // Separated data pulse
  input  logic                  separated_clock_in,  // Separated clock pulse
  output logic                  data_request_out,    // Data register request
  output logic                  completion_irq,      // Command ended
  output logic                  head_load_out,       // Head load
  output logic                  write_gate_out,      // Write gate
  output logic                  write_serial_line    // FM write stream
);

  floppy_pkg::cmd_kind_e  kind_q, kind_d;
  floppy_pkg::fmt_state_e fmt_q, fmt_d;
  logic        busy_q, busy_d, hld_q, hld_d, irq_q, irq_d, drq_q, drq_d, lost_q, lost_d;
  logic        seek_q, seek_d, crce_q, crce_d, rnf_q, rnf_d, wp_q, wp_d;
  logic [1:0]  rtype_q, rtype_d;
  logic [7:0]  stat_q, stat_d, stat_now, rbyte_q, rbyte_d, rsh_q, rsh_d;
  logic [2:0]  rcnt_q, rcnt_d;
  logic        dseen_q, dseen_d, sclk_q, idx_q, idxseen_q, idxseen_d, wg_q, wg_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0]  wbyte, feed_data, feed_clk, buf_data;
  logic        prot, is_wr, refuse, accept, t1, rd_view, wr_view, reading;
  logic        idx_edge, sclk_edge, byte_done, take, buf_valid, buf_ready, pop;
  logic        lost_wr, wt_end;

  ////////////////////////////////////////////////////////////////////////////
  // Command, flags and status view
  always_comb begin
    prot    = ~write_protect_in;
    is_wr   = cmd_kind inside {floppy_pkg::K_WREC, floppy_pkg::K_WTRK};
    refuse  = cmd_load & ~cmd_force_int & (((cmd_kind != floppy_pkg::K_TYPE1)
              & ~drive_ready_in) | (is_wr & prot));
    accept  = cmd_load & ~cmd_force_int & ~refuse;
    kind_d  = kind_q;
    busy_d  = busy_q;
    hld_d   = hld_q;
    irq_d   = irq_q & ~status_rd;
    seek_d  = seek_q;
    crce_d  = crce_q;
    rnf_d   = rnf_q;
    wp_d    = wp_q;
    rtype_d = rtype_q;
    lost_d  = lost_q;
    drq_d   = drq_q;
    if (cmd_load) begin
      kind_d  = cmd_force_int ? floppy_pkg::K_TYPE1 : cmd_kind;
      {seek_d, crce_d, rnf_d, wp_d, lost_d, drq_d} = 6'h00;
      rtype_d = 2'h0;
    end
    if (accept) begin
      busy_d = 1'b1;
      hld_d  = 1'b1;
    end
    if (refuse) begin
      irq_d = 1'b1;
      wp_d  = is_wr & prot;
    end
    // Conditions other than zero are treated as zero here: terminate silently
    if (cmd_force_int) begin
      busy_d = 1'b0;
      hld_d  = 1'b0;
    end
    if (busy_q && !cmd_load && ((cmd_done && kind_q != floppy_pkg::K_WTRK) || wt_end)) begin
      busy_d = 1'b0;
      irq_d  = 1'b1;
    end
    // Events set after the clears so a same-cycle event survives
    if (seek_err_evt) seek_d = 1'b1;
    if (crc_err_evt) crce_d = 1'b1;
    if (rnf_evt) rnf_d = 1'b1;
    if (rec_type_evt) rtype_d = rec_type;
    if (data_rd) drq_d = 1'b0;
    // DATA_REQUEST_OUT drops for one cycle after each write so it never shows a stale free slot
    if (kind_q == floppy_pkg::K_WTRK && busy_q && !cmd_load) begin
      drq_d = buf_ready & ~data_wr & ~wt_end;
    end
    if (byte_done) drq_d = 1'b1;
    if ((byte_done && drq_q && !data_rd) || lost_wr) lost_d = 1'b1;

    t1      = (kind_q == floppy_pkg::K_TYPE1);
    rd_view = kind_q inside {floppy_pkg::K_RADDR, floppy_pkg::K_RREC, floppy_pkg::K_WREC};
    wr_view = kind_q inside {floppy_pkg::K_WREC, floppy_pkg::K_WTRK};
    stat_now[floppy_pkg::ST_NRDY] = ~drive_ready_in;
    stat_now[floppy_pkg::ST_B6]   = t1 ? prot : (kind_q == floppy_pkg::K_RREC) ? rtype_q[1]
                                    : wr_view & wp_q;
    stat_now[floppy_pkg::ST_B5]   = t1 ? (hld_q & head_load_timing_in)
                                    : (kind_q == floppy_pkg::K_RREC) & rtype_q[0];
    stat_now[floppy_pkg::ST_B4]   = t1 ? seek_q : rd_view & rnf_q;
    stat_now[floppy_pkg::ST_B3]   = t1 ? crce_q : rd_view & crce_q;
    stat_now[floppy_pkg::ST_B2]   = t1 ? ~track_zero_in : lost_q;
    stat_now[floppy_pkg::ST_B1]   = t1 ? ~index_pulse_in : drq_q;
    stat_now[floppy_pkg::ST_BUSY] = busy_q;
    // Snapshot keeps all eight bits from one cycle
    stat_d = status_rd ? stat_now : stat_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q  <= floppy_pkg::K_TYPE1;
      {busy_q, hld_q, irq_q, drq_q, lost_q} <= 5'h00;
      {seek_q, crce_q, rnf_q, wp_q} <= 4'h0;
      rtype_q <= 2'h0;
      stat_q  <= floppy_pkg::STATUS_RST;
    end else begin
      kind_q  <= kind_d;
      {busy_q, hld_q, irq_q, drq_q, lost_q} <= {busy_d, hld_d, irq_d, drq_d, lost_d};
      {seek_q, crce_q, rnf_q, wp_q} <= {seek_d, crce_d, rnf_d, wp_d};
      rtype_q <= rtype_d;
      stat_q  <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write track formatter
  always_comb begin
    idx_edge  = idx_q & ~index_pulse_in;
    fmt_d     = fmt_q;
    crc_d     = crc_q;
    idxseen_d = idxseen_q;
    pop       = 1'b0;
    lost_wr   = 1'b0;
    wt_end    = 1'b0;
    wbyte     = buf_valid ? buf_data : floppy_pkg::FILL;
    feed_data = floppy_pkg::FILL;
    feed_clk  = floppy_pkg::CLK_NORMAL;
    unique case (fmt_q)
      floppy_pkg::F_IDLE: begin
        if (accept && cmd_kind == floppy_pkg::K_WTRK) begin
          fmt_d     = floppy_pkg::F_WAIT;
          idxseen_d = 1'b0;
        end
      end
      floppy_pkg::F_WAIT: begin
        if (idx_edge && buf_valid) begin
          fmt_d = floppy_pkg::F_WRITE;
        end else if (idx_edge && idxseen_q) begin
          wt_end  = 1'b1;
          lost_wr = 1'b1;
          fmt_d   = floppy_pkg::F_IDLE;
        end else if (idx_edge) begin
          idxseen_d = 1'b1;
        end
      end
      floppy_pkg::F_WRITE: begin
        if (idx_edge) begin
          wt_end = 1'b1;
          fmt_d  = floppy_pkg::F_IDLE;
        end else if (take) begin
          pop     = buf_valid;
          lost_wr = ~buf_valid;
          if (wbyte == floppy_pkg::CRC_CMD) begin
            feed_data = crc_q[15:8];
            fmt_d     = floppy_pkg::F_CRC_LO;
          end else begin
            feed_data = wbyte;
            feed_clk  = floppy_pkg::clock_of(wbyte);
            crc_d     = floppy_pkg::crc_byte((wbyte >= floppy_pkg::MARK_LO) ?
                        floppy_pkg::CRC_INIT : crc_q, wbyte);
          end
        end
      end
      floppy_pkg::F_CRC_LO: begin
        if (idx_edge) begin
          wt_end = 1'b1;
          fmt_d  = floppy_pkg::F_IDLE;
        end else if (take) begin
          feed_data = crc_q[7:0];
          fmt_d     = floppy_pkg::F_WRITE;
        end
      end
    endcase
    if (cmd_force_int) fmt_d = floppy_pkg::F_IDLE;
    wg_d = fmt_d inside {floppy_pkg::F_WRITE, floppy_pkg::F_CRC_LO};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q     <= floppy_pkg::F_IDLE;
      crc_q     <= floppy_pkg::CRC_INIT;
      idxseen_q <= 1'b0;
      wg_q      <= 1'b0;
      idx_q     <= 1'b1;
    end else begin
      fmt_q     <= fmt_d;
      crc_q     <= crc_d;
      idxseen_q <= idxseen_d;
      wg_q      <= wg_d;
      idx_q     <= index_pulse_in;
    end
  end

  // Two entries let the host refill while the serializer holds one byte
  pair_buffer #(.W(8), .DEPTH(floppy_pkg::BUF_DEPTH)) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (data_wr & drq_q & (kind_q == floppy_pkg::K_WTRK)),
    .in_ready  (buf_ready),
    .in_data   (data_wr_byte),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  fm_serializer #(.HALF_CYC(floppy_pkg::HALF_CELL_CYC)) u_ser (
    .clk     (clk),
    .rst_n   (rst_n),
    .en      (wg_q),
    .data    (feed_data),
    .clk_pat (feed_clk),
    .take    (take),
    .line    (write_serial_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read byte assembly
  always_comb begin
    reading   = busy_q & (kind_q inside {floppy_pkg::K_RADDR, floppy_pkg::K_RREC,
                floppy_pkg::K_RTRK});
    sclk_edge = separated_clock_in & ~sclk_q;
    dseen_d   = dseen_q | separated_data_in;
    rsh_d     = rsh_q;
    rcnt_d    = rcnt_q;
    rbyte_d   = rbyte_q;
    byte_done = 1'b0;
    if (!reading) begin
      dseen_d = 1'b0;
      rcnt_d  = 3'h0;
    end else if (sclk_edge) begin
      rsh_d   = {dseen_q, rsh_q[7:1]};
      dseen_d = 1'b0;
      rcnt_d  = rcnt_q + 3'h1;
      if (rcnt_q == 3'h7) begin
        byte_done = 1'b1;
        rbyte_d   = rsh_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {dseen_q, sclk_q} <= 2'h0;
      rsh_q   <= 8'h00;
      rcnt_q  <= 3'h0;
      rbyte_q <= 8'h00;
    end else begin
      {dseen_q, sclk_q} <= {dseen_d, separated_clock_in};
      rsh_q   <= rsh_d;
      rcnt_q  <= rcnt_d;
      rbyte_q <= rbyte_d;
    end
  end

  assign status_data      = stat_q;
  assign read_byte        = rbyte_q;
  assign data_request_out = drq_q;
  assign completion_irq   = irq_q;
  assign head_load_out    = hld_q;
  assign write_gate_out   = wg_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence force_quiet;
    cmd_force_int && force_cond == 4'h0;
  endsequence
  sequence crc_request;
    fmt_q == floppy_pkg::F_WRITE && take && !idx_edge && buf_valid
      && buf_data == floppy_pkg::CRC_CMD;
  endsequence

  a_refuse_busy: assert property (cmd_load && !cmd_force_int && cmd_kind != floppy_pkg::K_TYPE1
    && !drive_ready_in && !busy_q |=> !busy_q)
    else $error("command ran with drive not ready");
  a_nrdy_read: assert property (status_rd |=> stat_q[7] == !$past(drive_ready_in))
    else $error("not ready bit wrong");
  a_drq_mirror: assert property (status_rd |=> stat_q[1] == $past(drq_q))
    else $error("status bit 1 does not mirror data request");
  a_type1_view: assert property (status_rd && kind_q == floppy_pkg::K_TYPE1 |=> stat_q[2]
    == !$past(track_zero_in) && stat_q[5] == $past(hld_q && head_load_timing_in))
    else $error("type I status view wrong");
  a_rtrk_zero: assert property (status_rd && kind_q == floppy_pkg::K_RTRK |=> stat_q[6:3] == 4'h0)
    else $error("unused read track bits not zero");
  a_force_term: assert property (force_quiet ##0 !irq_q |=> !busy_q
    && kind_q == floppy_pkg::K_TYPE1 && !irq_q)
    else $error("force interrupt did not end quietly");
  a_crc_pair: assert property (crc_request |=> fmt_q == floppy_pkg::F_CRC_LO)
    else $error("F7 did not start CRC emission");
  a_rnf_clear: assert property (cmd_load && !rnf_evt |=> !rnf_q)
    else $error("record not found survived new command");
  a_lost_set: assert property (byte_done && drq_q && !data_rd |=> lost_q)
    else $error("overrun not flagged");

endmodule : floppy_status_and_track_format

// File: fm_serializer.sv
`timescale 1ns/100ps

module fm_serializer #(
  parameter int HALF_CYC = 500
) (
  input  logic       clk,     // System clock
  input  logic       rst_n,   // Async reset, active low
  input  logic       en,      // Write gate, serializer runs while high
  input  logic [7:0] data,    // Data byte, sampled when take is high
  input  logic [7:0] clk_pat, // Clock pattern for that byte
  output logic       take,    // One-cycle pulse: byte sampled now
  output logic       line     // Serial FM cell stream
);

  localparam int CW = $clog2(HALF_CYC);

  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0]    ph_q, ph_d;
  logic [15:0]   cell_q, cell_d;
  logic          ld_q, ld_d, line_d, tick;

  always_comb begin
    tick   = (cnt_q == CW'(HALF_CYC - 1));
    take   = en & (~ld_q | (tick & (ph_q == 4'hF)));
    cnt_d  = (!en || !ld_q || tick) ? '0 : cnt_q + CW'(1);
    ph_d   = ph_q;
    cell_d = cell_q;
    ld_d   = en;
    if (!en) begin
      ph_d = 4'h0;
    end else if (tick) begin
      ph_d = ph_q + 4'h1;
    end
    // Clock cell precedes its data cell, bit 0 leaves first
    if (take) begin
      for (int i = 0; i < 8; i++) begin
        cell_d[2*i]   = clk_pat[i];
        cell_d[2*i+1] = data[i];
      end
    end
    line_d = (en && ld_q) ? cell_q[ph_q] : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      ph_q   <= 4'h0;
      cell_q <= 16'h0000;
      ld_q   <= 1'b0;
      line   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      ph_q   <= ph_d;
      cell_q <= cell_d;
      ld_q   <= ld_d;
      line   <= line_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counter measures the spacing of byte requests
  logic [15:0] gap_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= take ? 16'h0000 : gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_byte_spacing: assert property (take && ld_q |-> gap_q == 16'(16*HALF_CYC - 1))
    else $error("byte period is not sixteen half cells");
  a_line_idle: assert property (!en |=> !line)
    else $error("serial line active without write gate");

endmodule : fm_serializer

// File: pair_buffer.sv
`timescale 1ns/100ps

module pair_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  logic         clk,       // System clock
  input  logic         rst_n,     // Async reset, active low
  input  logic         in_valid,  // Word offered
  output logic         in_ready,  // Room for a word
  input  logic [W-1:0] in_data,   // Offered word
  output logic         out_valid, // Word available
  input  logic         out_ready, // Drain accepts word
  output logic [W-1:0] out_data   // Oldest word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_q != (PW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rp_q];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    mem_d     = mem_q;
    wp_d      = wp_q;
    rp_d      = rp_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
    end
    if (pop) begin
      rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
    end
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_count_bound: assert property (cnt_q <= (PW+1)'(DEPTH))
    else $error("buffer count beyond depth");
  a_push_lands: assert property (push && !pop && out_valid |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("accepted word not counted");

endmodule : pair_buffer

// File: tb.sv
`timescale 1ns/100ps

module tb;
  localparam logic [9:0] RD = 10'h040, LD = 10'h080, FI = 10'h020, DN = 10'h010;
  logic                  clk, rst_n;
  logic [9:0]            ev;
  floppy_pkg::cmd_kind_e kind;
  logic [7:0]            status_data, read_byte;
  logic                  drive_ready_in, write_protect_in, head_load_timing_in, track_zero_in;
  logic                  index_pulse_in, separated_data_in, separated_clock_in, data_request_out;
  logic                  completion_irq, head_load_out, write_gate_out, write_serial_line;
  int                    fails, n_compared, cyc, i;

  drive_model drv (.clk, .drive_ready_in, .write_protect_in, .head_load_timing_in,
    .track_zero_in, .index_pulse_in, .separated_data_in, .separated_clock_in);
  floppy_status_and_track_format dut (.clk, .rst_n, .cmd_load(ev[7]), .cmd_kind(kind),
    .cmd_force_int(ev[5]), .force_cond(4'h0), .cmd_done(ev[4]), .seek_err_evt(ev[0]),
    .crc_err_evt(ev[1]), .rnf_evt(ev[2]), .rec_type_evt(ev[3]), .rec_type(2'h2),
    .drive_ready_in, .write_protect_in, .head_load_timing_in, .track_zero_in,
    .index_pulse_in, .status_rd(ev[6]), .status_data, .data_wr(ev[9]),
    .data_wr_byte(8'h5A), .data_rd(ev[8]), .read_byte, .separated_data_in,
    .separated_clock_in, .data_request_out, .completion_irq, .head_load_out,
    .write_gate_out, .write_serial_line);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Compared %0d, errors %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One-cycle strobe; returns after the following edge has settled
  task automatic puls(input logic [9:0] m, input floppy_pkg::cmd_kind_e k = floppy_pkg::K_TYPE1);
    @(posedge clk) ev <= m;
    kind <= k;
    @(posedge clk) ev <= 10'h000;
    #1;
  endtask : puls
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    puls(RD);
    chk(status_data & m, e);
  endtask : st
  ////////////////////////////////////////////////////////////////////////////////
  task automatic type1_view();
    @(posedge clk) drv.write_protect_in <= 1'b0;
    drv.track_zero_in <= 1'b0;
    puls(LD);
    st(8'hFF, 8'h65);
    puls(10'h003);
    st(8'hFF, 8'h7D);
    puls(LD | FI);
    chk({7'h0, completion_irq}, 8'h00);
    st(8'hA1, 8'h00);
  endtask : type1_view
  task automatic refused();
    @(posedge clk) drv.drive_ready_in <= 1'b0;
    puls(LD, floppy_pkg::K_RREC);
    chk({7'h0, completion_irq}, 8'h01);
    st(8'h81, 8'h80);
    chk({7'h0, completion_irq}, 8'h00);
    @(posedge clk) drv.drive_ready_in <= 1'b1;
  endtask : refused
  task automatic unused_bits();
    puls(LD, floppy_pkg::K_RADDR);
    puls(10'h008);
    st(8'h60, 8'h00);
    puls(LD, floppy_pkg::K_RTRK);
    puls(10'h00F);
    st(8'h78, 8'h00);
    puls(LD | FI);
  endtask : unused_bits
  task automatic read_record();
    puls(LD, floppy_pkg::K_RREC);
    puls(10'h00E);
    drv.send_byte(8'hA5);
    repeat (3) @(posedge clk);
    #1;
    chk(read_byte, 8'hA5);
    st(8'hFF, 8'h5B);
    puls(10'h100);
    puls(DN);
    chk({7'h0, completion_irq}, 8'h01);
    st(8'hFF, 8'h58);
  endtask : read_record
  task automatic write_track();
    @(posedge clk) drv.write_protect_in <= 1'b1;
    puls(LD, floppy_pkg::K_WTRK);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, data_request_out}, 8'h01);
    puls(10'h200);
    fork
      drv.index_mark();
    join_none
    for (i = 0; i < 20 && write_gate_out !== 1'b1; i++) @(posedge clk) #1;
    repeat (252) @(posedge clk);
    @(negedge clk);
    for (int j = 0; j < 16; j++) begin
      chk({7'h0, write_serial_line}, j[0] ? ((8'h5A >> (j / 2)) & 8'h01) : 8'h01);
      repeat (500) @(negedge clk);
    end
    st(8'h04, 8'h04);
    puls(LD | FI);
  endtask : write_track
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ev = 10'h000;
    kind = floppy_pkg::K_TYPE1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(status_data, 8'h80);
    type1_view();
    refused();
    unused_bits();
    read_record();
    write_track();
    give_verdict();
  end
endmodule : tb
